// file: core/acmpc_pkg.sv
// Package for the comparator control block: offsets, fields, reset values, carrier types.
// Assumes a 32-bit AXI4-Lite register bus and a single peripheral clock.
package acmpc_pkg;
    localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
    localparam logic [3:0]  ADDR_DISABLE   = 4'h4;
    localparam logic [3:0]  ADDR_STATUS    = 4'h8;
    localparam logic [3:0]  ADDR_MASK      = 4'hC;

    localparam int          BIT_ON         = 15;
    localparam int          BIT_PIN_DRIVE  = 14;
    localparam int          BIT_INVERT     = 13;
    localparam int          BIT_LIVE       = 8;
    localparam int          BIT_EDGE_LO    = 6;
    localparam int          BIT_POS_SEL    = 4;
    localparam int          BIT_NEG_LO     = 0;

    localparam logic [31:0] CONTROL_WMASK  = 32'h0000_E0D3;
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_00C3;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        ACMPC_EDGE_NONE = 2'b00,
        ACMPC_EDGE_RISE = 2'b01,
        ACMPC_EDGE_FALL = 2'b10,
        ACMPC_EDGE_BOTH = 2'b11
    } acmpc_edge_t;

    typedef enum logic [1:0] {
        ACMPC_NEG_PIN_B = 2'b00,
        ACMPC_NEG_PIN_C = 2'b01,
        ACMPC_NEG_PIN_D = 2'b10,
        ACMPC_NEG_BANDGAP = 2'b11
    } acmpc_neg_t;

    typedef struct packed {
        logic        on;
        logic        pinDrive;
        logic        invert;
        acmpc_edge_t edgeSel;
        logic        posSel;
        acmpc_neg_t  negSel;
    } acmpc_ctrl_t;

    typedef struct packed {
        logic        compEnable;
        logic        posSelRef;
        acmpc_neg_t  negSel;
    } acmpc_analog_t;
endpackage

// file: core/acmpc_sync.sv
// Two-flop synchroniser for the asynchronous comparator result.
// Assumes a free-running clock; the first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module acmpc_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic asyncIn,
    output var  logic syncOut
);
    logic stage1_ff;
    logic stage2_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule // acmpc_sync
`default_nettype wire

// file: core/acmpc_edge.sv
// Edge detector with selectable edges on an already synchronous level.
// Assumes the input is in the clk domain.
`timescale 1ns/1ns
`default_nettype none
module acmpc_edge (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  level,
    input  wire acmpc_pkg::acmpc_edge_t edgeSel,
    output var  logic                  eventPulse
);
    logic prev_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    always_comb begin
        case (edgeSel)
            acmpc_pkg::ACMPC_EDGE_RISE: eventPulse = level & ~prev_ff;
            acmpc_pkg::ACMPC_EDGE_FALL: eventPulse = ~level & prev_ff;
            acmpc_pkg::ACMPC_EDGE_BOTH: eventPulse = level ^ prev_ff;
            default:                    eventPulse = 1'b0;
        endcase
    end
endmodule // acmpc_edge
`default_nettype wire

// file: core/acmpc_top.sv
// Comparator control block: control register, pin drive, event and interrupt logic.
// Assumes an AXI4-Lite master, the analog core outside, and a synchronous reset.
// Functional notes
// R1 - Enable bit 15 switches comparator on or off; other fields keep their values.
// R2 - Pin drive bit 14 puts the result on the output pin.
// R3 - Invert bit 13 inverts the comparator result.
// R4 - Inversion also feeds the event detector, flipping the chosen edge.
// R5 - Bit 8 reads the live result, zero after reset, not writable.
// R6 - Edge field bits 7-6: both, falling, rising, or no events.
// R7 - Positive select bit 4 picks internal reference or pin A.
// R8 - Negative select bits 1-0 pick bandgap, pin D, pin C or pin B.
// R9 - Unimplemented bits read zero and ignore writes.
// R10 - Software skips register access right after clearing enable at 1:1 divisor.
// R11 - With module disabled, writes do nothing and reads return no valid data; only the control register here is frozen and reads zero.
// R12 - Disable bit is set to disable, clear to enable, cleared at reset.
// R13 - Software clears enable before setting the disable bit.
// R14 - Result is synchronised; one-cycle event pulse on the selected edge.
// R15 - Reset value: edge field and negative select all ones, rest zero.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module acmpc_top (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [3:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output var  logic                     s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output var  logic                     s_axi_wready,
    output var  logic [1:0]               s_axi_bresp,
    output var  logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [3:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output var  logic                     s_axi_arready,
    output var  logic [31:0]              s_axi_rdata,
    output var  logic [1:0]               s_axi_rresp,
    output var  logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     compResultAsync,
    output var  acmpc_pkg::acmpc_analog_t analogCtrl,
    output var  logic                     comparatorOutputPin,
    output var  logic                     comparatorOutputPinEn,
    output var  logic                     eventPulse,
    output var  logic                     irq
);
    acmpc_pkg::acmpc_ctrl_t ctrl_ff;
    logic                   disable_ff;
    logic                   status_ff;
    logic                   mask_ff;
    logic                   live_ff;
    logic                   pinOut_ff;
    logic                   pinEn_ff;
    logic [3:0]             awAddr_ff;
    logic                   awHave_ff;
    logic [31:0]            wData_ff;
    logic [3:0]             wStrb_ff;
    logic                   wHave_ff;
    logic                   bValid_ff;
    logic [1:0]             bResp_ff;
    logic                   rValid_ff;
    logic [31:0]            rData_ff;
    logic [1:0]             rResp_ff;
    logic                   resultSync;
    logic                   resultShown;
    logic                   rawEvent;
    logic                   doWrite;
    logic [31:0]            wFull;
    logic [31:0]            ctrlWord;
    logic [31:0]            nxt_ctrlWord;
    logic [31:0]            readWord;
    logic                   readOk;
    logic                   writeOk;

    acmpc_sync u_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (compResultAsync),
        .syncOut (resultSync)
    );

    // Polarity applied before the edge detector [R3] [R4]
    assign resultShown = (resultSync ^ ctrl_ff.invert) & ctrl_ff.on & ~disable_ff;

    acmpc_edge u_edge (
        .clk        (clk),
        .rst        (rst),
        .level      (resultShown),
        .edgeSel    (ctrl_ff.edgeSel),
        .eventPulse (rawEvent)
    );

    assign eventPulse = rawEvent; // [R14] [R6]

    // Live result register [R5]
    always_ff @(posedge clk) begin
        if (rst) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= resultShown;
        end
    end

    // Output pin drive; enable is active low [R2]
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOut_ff <= 1'b0;
            pinEn_ff  <= 1'b1;
        end else begin
            pinOut_ff <= resultShown;
            pinEn_ff  <= ~(ctrl_ff.pinDrive & ctrl_ff.on & ~disable_ff);
        end
    end

    assign comparatorOutputPin   = pinOut_ff;
    assign comparatorOutputPinEn = pinEn_ff;
    assign analogCtrl = '{compEnable: ctrl_ff.on & ~disable_ff, // [R1] [R11]
                          posSelRef:  ctrl_ff.posSel,           // [R7]
                          negSel:     ctrl_ff.negSel};          // [R8]

    // Write channel capture
    assign s_axi_awready = ~awHave_ff & ~bValid_ff;
    assign s_axi_wready  = ~wHave_ff & ~bValid_ff;
    assign doWrite       = awHave_ff & wHave_ff & ~bValid_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            awAddr_ff <= 4'h0;
            awHave_ff <= 1'b0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            awAddr_ff <= s_axi_awaddr;
            awHave_ff <= 1'b1;
        end else if (doWrite) begin
            awHave_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            wHave_ff <= 1'b0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
            wHave_ff <= 1'b1;
        end else if (doWrite) begin
            wHave_ff <= 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wFull[i*8 +: 8] = {8{wStrb_ff[i]}};
        end
    end

    assign ctrlWord = {16'h0000, ctrl_ff.on, ctrl_ff.pinDrive, ctrl_ff.invert, 5'h00,
                       ctrl_ff.edgeSel, 1'b0, ctrl_ff.posSel, 2'h0, ctrl_ff.negSel};
    assign nxt_ctrlWord = (ctrlWord & ~(wFull & acmpc_pkg::CONTROL_WMASK))
                        | (wData_ff & wFull & acmpc_pkg::CONTROL_WMASK); // [R9] [R1]
    assign writeOk = (awAddr_ff == acmpc_pkg::ADDR_CONTROL) | (awAddr_ff == acmpc_pkg::ADDR_DISABLE)
                   | (awAddr_ff == acmpc_pkg::ADDR_STATUS) | (awAddr_ff == acmpc_pkg::ADDR_MASK);

    // Control register; frozen while module disabled [R11] [R15]
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff.on       <= 1'b0;
            ctrl_ff.pinDrive <= 1'b0;
            ctrl_ff.invert   <= 1'b0;
            ctrl_ff.edgeSel  <= acmpc_pkg::acmpc_edge_t'(acmpc_pkg::CONTROL_RESET[7:6]);
            ctrl_ff.posSel   <= 1'b0;
            ctrl_ff.negSel   <= acmpc_pkg::acmpc_neg_t'(acmpc_pkg::CONTROL_RESET[1:0]);
        end else if (doWrite & ~disable_ff & (awAddr_ff == acmpc_pkg::ADDR_CONTROL)) begin
            ctrl_ff.on       <= nxt_ctrlWord[acmpc_pkg::BIT_ON];
            ctrl_ff.pinDrive <= nxt_ctrlWord[acmpc_pkg::BIT_PIN_DRIVE];
            ctrl_ff.invert   <= nxt_ctrlWord[acmpc_pkg::BIT_INVERT];
            ctrl_ff.edgeSel  <= acmpc_pkg::acmpc_edge_t'(nxt_ctrlWord[acmpc_pkg::BIT_EDGE_LO +: 2]);
            ctrl_ff.posSel   <= nxt_ctrlWord[acmpc_pkg::BIT_POS_SEL];
            ctrl_ff.negSel   <= acmpc_pkg::acmpc_neg_t'(nxt_ctrlWord[acmpc_pkg::BIT_NEG_LO +: 2]);
        end
    end

    // Module disable bit, cleared at reset [R12]
    always_ff @(posedge clk) begin
        if (rst) begin
            disable_ff <= 1'b0;
        end else if (doWrite & wStrb_ff[0] & (awAddr_ff == acmpc_pkg::ADDR_DISABLE)) begin
            disable_ff <= wData_ff[0];
        end
    end

    // Sticky event status, set wins over write-one-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= 1'b0;
        end else if (rawEvent) begin
            status_ff <= 1'b1;
        end else if (doWrite & wStrb_ff[0] & wData_ff[0] & (awAddr_ff == acmpc_pkg::ADDR_STATUS)) begin
            status_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_ff <= 1'b0;
        end else if (doWrite & wStrb_ff[0] & (awAddr_ff == acmpc_pkg::ADDR_MASK)) begin
            mask_ff <= wData_ff[0];
        end
    end

    assign irq = status_ff & mask_ff;

    // Write response
    always_ff @(posedge clk) begin
        if (rst) begin
            bValid_ff <= 1'b0;
            bResp_ff  <= acmpc_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff  <= writeOk ? acmpc_pkg::RESP_OKAY : acmpc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp  = bResp_ff;

    // Read path; control reads zero while disabled [R11] [R9] [R5]
    always_comb begin
        readWord = 32'h0000_0000;
        readOk   = 1'b1;
        case (s_axi_araddr)
            acmpc_pkg::ADDR_CONTROL: begin
                readWord = disable_ff ? 32'h0000_0000 : ctrlWord;
                readWord[acmpc_pkg::BIT_LIVE] = live_ff & ~disable_ff;
            end
            acmpc_pkg::ADDR_DISABLE: readWord[0] = disable_ff;
            acmpc_pkg::ADDR_STATUS:  readWord[0] = status_ff;
            acmpc_pkg::ADDR_MASK:    readWord[0] = mask_ff;
            default:                 readOk = 1'b0;
        endcase
    end

    assign s_axi_arready = ~rValid_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            rValid_ff <= 1'b0;
            rData_ff  <= 32'h0000_0000;
            rResp_ff  <= acmpc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            rValid_ff <= 1'b1;
            rData_ff  <= readWord;
            rResp_ff  <= readOk ? acmpc_pkg::RESP_OKAY : acmpc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata  = rData_ff;
    assign s_axi_rresp  = rResp_ff;

    // Assertions
    property p_onKeeps;
        @(posedge clk) disable iff (rst)
        $changed(ctrl_ff.on) |-> $stable(ctrl_ff.edgeSel) || $past(doWrite);
    endproperty
    a_onKeeps: assert property (p_onKeeps) else $error("enable change disturbed other fields"); // [R1]

    property p_pinDrive;
        @(posedge clk) disable iff (rst)
        (ctrl_ff.pinDrive & ctrl_ff.on & ~disable_ff) |=> !comparatorOutputPinEn;
    endproperty
    a_pinDrive: assert property (p_pinDrive) else $error("pin not driven when enabled"); // [R2]

    property p_pinOff;
        @(posedge clk) disable iff (rst)
        !ctrl_ff.pinDrive |=> comparatorOutputPinEn;
    endproperty
    a_pinOff: assert property (p_pinOff) else $error("pin driven while drive off"); // [R2]

    property p_invert;
        @(posedge clk) disable iff (rst)
        (ctrl_ff.on & ~disable_ff) |-> resultShown == (resultSync ^ ctrl_ff.invert);
    endproperty
    a_invert: assert property (p_invert) else $error("polarity wrong"); // [R3]

    property p_live;
        @(posedge clk) disable iff (rst)
        1'b1 |=> live_ff == $past(resultShown);
    endproperty
    a_live: assert property (p_live) else $error("live bit stale"); // [R5]

    property p_noEvent;
        @(posedge clk) disable iff (rst)
        ctrl_ff.edgeSel == acmpc_pkg::ACMPC_EDGE_NONE |-> !eventPulse;
    endproperty
    a_noEvent: assert property (p_noEvent) else $error("event while disabled"); // [R6]

    property p_rise;
        @(posedge clk) disable iff (rst)
        (ctrl_ff.edgeSel == acmpc_pkg::ACMPC_EDGE_RISE) && $rose(resultShown) |-> eventPulse;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed"); // [R14]

    property p_pulseOne;
        @(posedge clk) disable iff (rst)
        eventPulse && $stable(ctrl_ff.edgeSel) |=> !eventPulse || $changed(resultShown);
    endproperty
    a_pulseOne: assert property (p_pulseOne) else $error("event pulse too long"); // [R14]

    property p_reserved;
        @(posedge clk) disable iff (rst)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12:9] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // [R9]

    property p_frozen;
        @(posedge clk) disable iff (rst)
        disable_ff |=> $stable(ctrl_ff);
    endproperty
    a_frozen: assert property (p_frozen) else $error("control changed while disabled"); // [R11]

    c_event:   cover property (@(posedge clk) disable iff (rst) eventPulse);
    c_irq:     cover property (@(posedge clk) disable iff (rst) $rose(irq));
    c_disable: cover property (@(posedge clk) disable iff (rst) $rose(disable_ff));
endmodule // acmpc_top
`default_nettype wire

// file: tb/acmpc_core_model.sv
// Behavioural model of the analog comparator core with its input pins and references.
// Assumes the bench drives the six input levels; index 0 pin A, 1 reference, 2..4 pins B..D, 5 bandgap.
`timescale 1ns/1ns
`default_nettype none
module acmpc_core_model (
    input  wire acmpc_pkg::acmpc_analog_t ctrl,
    input  wire logic [5:0][7:0]          levels,
    output var  logic                     result
);
    logic [7:0] posV;
    logic [7:0] negV;

    always_comb begin
        posV = ctrl.posSelRef ? levels[1] : levels[0];
        negV = levels[3'd2 + {1'b0, ctrl.negSel}];
        result = ctrl.compEnable && (posV > negV);
    end
endmodule // acmpc_core_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the comparator control block over AXI4-Lite.
// Assumes the core model on the analog side and a 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                     clk;
    logic                     rst;
    logic [3:0]               awAddr, arAddr, wStrb;
    logic [31:0]              wData, rData, rd;
    logic                     awValid, awReady, wValid, wReady, bValid, bReady;
    logic                     arValid, arReady, rValid, rReady;
    logic [1:0]               bResp, rResp, rsp;
    logic                     compRes, pinOut, pinOutEn, evPulse, irq;
    acmpc_pkg::acmpc_analog_t analogCtrl;
    logic [5:0][7:0]          levels;
    logic                     res, rise, fall;
    logic [31:0]              ctl;
    int                       mismatches = 0;
    int                       totalChecks = 0;
    int                       evCount = 0;
    int                       base;

    acmpc_top acmpc_top_i (.clk(clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .compResultAsync(compRes), .analogCtrl(analogCtrl), .comparatorOutputPin(pinOut),
        .comparatorOutputPinEn(pinOutEn), .eventPulse(evPulse), .irq(irq));

    acmpc_core_model acmpc_core_model_i (.ctrl(analogCtrl), .levels(levels), .result(compRes));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Counts event pulse cycles
    always @(posedge clk) begin
        if (evPulse === 1'b1) evCount <= evCount + 1;
    end

    task automatic test_done();
        if (mismatches == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic giveUp(input int n);
        if (n >= 50) begin
            mismatches++;
            $display("CHECK FAILED at %0t: bus answer timed out", $time);
            test_done();
        end
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        awAddr <= a; awValid <= 1'b1; wData <= d; wStrb <= 4'hF; wValid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid && n < 50);
        giveUp(n);
        r = bResp;
    endtask

    task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        arAddr <= a; arValid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arReady) arValid <= 1'b0;
        end while (!rValid && n < 50);
        giveUp(n);
        d = rData;
        r = rResp;
    endtask

    task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
        axiWrite(a, d, rsp);
        check(32'(rsp), 32'(acmpc_pkg::RESP_OKAY), "write response");
    endtask

    task automatic rdReg(input logic [3:0] a);
        axiRead(a, rd, rsp);
        check(32'(rsp), 32'(acmpc_pkg::RESP_OKAY), "read response");
    endtask

    initial begin
        // Response ready lines stay high so back-to-back calls never drive them twice in one step
        rst = 1'b1; awValid = 1'b0; wValid = 1'b0; bReady = 1'b1; arValid = 1'b0; rReady = 1'b1;
        awAddr = 4'h0; arAddr = 4'h0; wData = 32'h0; wStrb = 4'h0;
        levels = {8'd120, 8'd40, 8'd150, 8'd60, 8'd50, 8'd100};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, acmpc_pkg::CONTROL_RESET, "control after reset");
        rdReg(acmpc_pkg::ADDR_DISABLE);
        check(rd, 32'h0000_0000, "disable after reset");
        check(32'({pinOutEn, irq}), 32'h0000_0002, "pin and irq after reset");
        // Unused positions stay zero
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'hFFFF_FFFF);
        repeat (6) @(posedge clk);
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_E1D3, "all ones written");
        // Input routing, live bit and pin drive
        for (int p = 0; p < 2; p++) begin
            for (int n = 0; n < 4; n++) begin
                ctl = 32'h0000_C000 | (32'(p) << 4) | 32'(n);
                wrReg(acmpc_pkg::ADDR_CONTROL, ctl);
                repeat (6) @(posedge clk);
                res = levels[p] > levels[2 + n];
                rdReg(acmpc_pkg::ADDR_CONTROL);
                check(rd, ctl | (32'(res) << 8), "live result");
                check(32'(analogCtrl), {28'h0, 1'b1, p[0], n[1:0]}, "analog select");
                check(32'({pinOutEn, pinOut}), 32'(res), "pin drive");
            end
        end
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_E000);
        repeat (6) @(posedge clk);
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_E000, "inverted live bit");
        check(32'({pinOutEn, pinOut}), 32'h0000_0000, "inverted pin");
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_A000);
        repeat (6) @(posedge clk);
        check(32'(pinOutEn), 32'h0000_0001, "pin released");
        // Enable toggles alone; a read follows the clear of enable at once
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_6092);
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_6092, "fields with enable off");
        check(32'(analogCtrl.compEnable), 32'h0, "comparator off");
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_E092);
        repeat (6) @(posedge clk);
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_E092, "fields with enable on");
        // Module disable, enable cleared first
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_6092);
        wrReg(acmpc_pkg::ADDR_DISABLE, 32'h0000_0001);
        rdReg(acmpc_pkg::ADDR_DISABLE);
        check(rd, 32'h0000_0001, "disable set");
        wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_0011);
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_0000, "read while disabled");
        wrReg(acmpc_pkg::ADDR_DISABLE, 32'h0000_0000);
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_6092, "write ignored while disabled");
        // Unmapped address
        axiRead(4'h2, rd, rsp);
        check(32'(rsp), 32'(acmpc_pkg::RESP_SLVERR), "unmapped read");
        axiWrite(4'h2, 32'h0000_FFFF, rsp);
        check(32'(rsp), 32'(acmpc_pkg::RESP_SLVERR), "unmapped write");
        rdReg(acmpc_pkg::ADDR_CONTROL);
        check(rd, 32'h0000_6092, "unmapped write has no effect");
        // Event edges with and without inversion
        wrReg(acmpc_pkg::ADDR_MASK, 32'h0000_0001);
        for (int inv = 0; inv < 2; inv++) begin
            for (int e = 0; e < 4; e++) begin
                levels[0] <= 8'd10;
                wrReg(acmpc_pkg::ADDR_CONTROL, 32'h0000_8000 | (32'(inv) << 13) | (32'(e) << 6));
                repeat (6) @(posedge clk);
                wrReg(acmpc_pkg::ADDR_STATUS, 32'h0000_0001);
                base = evCount;
                rise = inv[0] ? e[1] : e[0];
                fall = inv[0] ? e[0] : e[1];
                levels[0] <= 8'd100;
                repeat (6) @(posedge clk);
                check(32'(evCount - base), 32'(rise), "events on rise");
                levels[0] <= 8'd10;
                repeat (6) @(posedge clk);
                check(32'(evCount - base), 32'(rise) + 32'(fall), "events on fall");
                rdReg(acmpc_pkg::ADDR_STATUS);
                check(rd, 32'(rise | fall), "sticky status");
                check(32'(irq), 32'(rise | fall), "irq level");
            end
        end
        wrReg(acmpc_pkg::ADDR_MASK, 32'h0000_0000);
        check(32'(irq), 32'h0, "irq masked");
        rdReg(acmpc_pkg::ADDR_STATUS);
        check(rd, 32'h0000_0001, "status held under mask");
        wrReg(acmpc_pkg::ADDR_STATUS, 32'h0000_0001);
        rdReg(acmpc_pkg::ADDR_STATUS);
        check(rd, 32'h0000_0000, "status cleared");
        test_done();
    end
endmodule // testbench
`default_nettype wire
